/* File: hdl/asr_map.svh */
// Constants for the host controller of the 2K x 8 asynchronous static RAM.
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

`define ASR_WORDS     2048
`define ASR_ADDR_W    11
`define ASR_DATA_W    8
`define ASR_TMR_W     5

`define ASR_CLK_NS    10
`define ASR_T_RC_NS   120
`define ASR_T_CW_NS   70
`define ASR_T_AW_NS   105
`define ASR_T_DW_NS   35
`define ASR_T_WR_NS   0
`define ASR_T_CHZ_NS  40
`define ASR_DESELECT_TO_RETENTION_TIME_NS  0

`define ASR_CEIL(t)   (((t) + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_MAX(a, b) (((a) > (b)) ? (a) : (b))

`define ASR_RC_CYC    `ASR_CEIL(`ASR_T_RC_NS)
`define ASR_WLO_CYC   `ASR_MAX(`ASR_CEIL(`ASR_T_CW_NS), \
                      `ASR_MAX(`ASR_CEIL(`ASR_T_AW_NS), \
                               `ASR_CEIL(`ASR_T_DW_NS)))
`define ASR_HZ_CYC    `ASR_MAX(1, `ASR_CEIL(`ASR_T_CHZ_NS))

`define ASR_IDLE_STROBE 1'b1

`endif

/* File: hdl/asr_pkg.sv */
// Types shared by the static RAM host controller modules.
`include "asr_map.svh"

package asr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RD    = 3'b001,
        ST_WR    = 3'b010,
        ST_WEND  = 3'b011,
        ST_TURN  = 3'b100,
        ST_RET   = 3'b101,
        ST_RECOV = 3'b110
    } asr_state_t;

    typedef struct packed {
        logic                   write;
        logic [`ASR_ADDR_W-1:0] addr;
        logic [`ASR_DATA_W-1:0] wdata;
    } asr_req_t;

    typedef struct packed {
        logic                   valid;
        logic [`ASR_DATA_W-1:0] data;
    } asr_rsp_t;

    typedef struct packed {
        logic [`ASR_ADDR_W-1:0] addr;
        logic                   cs_n;
        logic                   oe_n;
        logic                   we_n;
        logic [`ASR_DATA_W-1:0] dout;
        logic                   dq_oe_n;
    } asr_pins_t;

    typedef struct packed {
        asr_state_t st;
        asr_pins_t  pins;
        logic       ready;
        logic       retained;
    } asr_host_state_t;

    typedef struct packed {
        logic [`ASR_TMR_W-1:0] count;
    } asr_tmr_state_t;

endpackage

/* File: hdl/asr_timer.sv */
// Loadable down counter that times each phase of a memory cycle.
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_timer
    import asr_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  nrst,
    input  wire logic                  load,
    input  wire logic [`ASR_TMR_W-1:0] load_val,
    output logic                       done
);

    asr_tmr_state_t q;
    asr_tmr_state_t d;

    always_comb begin
        d = q;
        if (load) begin
            d.count = load_val;
        end else if (q.count != '0) begin
            d.count = q.count - `ASR_TMR_W'(1);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign done = (q.count == '0);

endmodule

/* File: hdl/asr_capture.sv */
// Register that samples the memory data pins at the end of a read.
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_capture
    import asr_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  nrst,
    input  wire logic                  cap_en,
    input  wire logic [`ASR_DATA_W-1:0] din,
    output asr_rsp_t                   rsp
);

    asr_rsp_t d;

    always_comb begin
        d = rsp;
        d.valid = cap_en;
        if (cap_en) begin
            d.data = din;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rsp <= '0;
        end else begin
            rsp <= d;
        end
    end

endmodule

/* File: hdl/asr_host.sv */
// Host controller that runs read and write cycles on a 2K x 8 static RAM.
// Function
// R1 - Memory holds 2048 bytes, eleven address lines.
// R2 - Memory needs no clock; levels control access.
// R3 - Write only while select and write both low.
// R4 - Select low at least 70 ns before end.
// R5 - Address stable 105 ns before write end.
// R6 - Write data valid 35 ns before end.
// R7 - Write recovery from first rising strobe, 0 ns.
// R8 - Reads keep write high, output enable low.
// R9 - Read data valid 120 ns after access start.
// R10 - Data valid 55 ns after output enable.
// R11 - Pins float within 40 ns of deselect.
// R12 - Pins float within 40 ns of enable high.
// R13 - Old read data held 10 ns after address.
// R14 - Pins float 35 ns after write falls.
// R15 - Host never drives against memory output.
// R16 - Select falling with write keeps pins floating.
// R17 - Driven value matches written data polarity.
// R18 - After write, pins show next address data.
// R19 - Memory waits 10 ns before driving again.
// R20 - Host stops driving when memory drives back.
// R21 - Read and write cycles last 120 ns minimum.
// R22 - Deselect before retention; wait cycle after it.
// R23 - Address valid no later than select falling.
// R24 - Deselected memory ignores strobes and floats pins.
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_host
    import asr_pkg::*;
#(
    parameter logic [`ASR_TMR_W-1:0] RC_CYC  = `ASR_TMR_W'(`ASR_RC_CYC),
    parameter logic [`ASR_TMR_W-1:0] WLO_CYC = `ASR_TMR_W'(`ASR_WLO_CYC),
    parameter logic [`ASR_TMR_W-1:0] HZ_CYC  = `ASR_TMR_W'(`ASR_HZ_CYC)
) (
    input  wire logic                   clock,
    input  wire logic                   nrst,
    input  wire logic                   req_valid,
    input  asr_req_t                    req,
    output logic                        req_ready,
    output asr_rsp_t                    rsp,
    input  wire logic                   retain_req,
    output logic                        retained,
    output asr_pins_t                   pins,
    input  wire logic [`ASR_DATA_W-1:0] sram_dq_i
);

    localparam asr_pins_t PINS_IDLE = '{
        addr:    '0,
        cs_n:    `ASR_IDLE_STROBE,
        oe_n:    `ASR_IDLE_STROBE,
        we_n:    `ASR_IDLE_STROBE,
        dout:    '0,
        dq_oe_n: `ASR_IDLE_STROBE
    };

    localparam asr_host_state_t STATE_RST = '{
        st:       ST_IDLE,
        pins:     PINS_IDLE,
        ready:    1'b1,
        retained: 1'b0
    };

    asr_host_state_t q;
    asr_host_state_t d;

    logic                  tmr_load;
    logic [`ASR_TMR_W-1:0] tmr_val;
    logic                  tmr_done;
    logic                  cap_en;

    function automatic logic [`ASR_TMR_W-1:0] phase_len(
        input logic [`ASR_TMR_W-1:0] cycles
    );
        phase_len = (cycles > `ASR_TMR_W'(1)) ?
                    cycles - `ASR_TMR_W'(1) : '0;
    endfunction

    always_comb begin
        d        = q;
        tmr_load = 1'b0;
        tmr_val  = '0;
        cap_en   = 1'b0;
        case (q.st)
            ST_IDLE: begin
                d.pins.dq_oe_n = 1'b1;
                if (req_valid && q.ready) begin
                    // Address, select and strobe move on the same edge. R23
                    d.ready     = 1'b0;
                    d.pins.addr = req.addr;
                    d.pins.cs_n = 1'b0;
                    tmr_load    = 1'b1;
                    if (req.write) begin
                        // Select falls with write, so memory stays floating. R16
                        d.st           = ST_WR;
                        d.pins.we_n    = 1'b0; // R3
                        d.pins.oe_n    = 1'b1; // R15
                        d.pins.dq_oe_n = 1'b0; // R6
                        d.pins.dout    = req.wdata;
                        tmr_val        = phase_len(WLO_CYC); // R4 R5
                    end else begin
                        d.st        = ST_RD;
                        d.pins.we_n = 1'b1; // R8
                        d.pins.oe_n = 1'b0; // R8
                        tmr_val     = phase_len(RC_CYC); // R9 R21
                    end
                end else if (retain_req) begin
                    d.st       = ST_RET; // R22
                    d.ready    = 1'b0;
                    d.retained = 1'b1;
                end
            end
            ST_WR: begin
                if (tmr_done) begin
                    // Both strobes rise together; data stays one more cycle.
                    d.st        = ST_WEND;
                    d.pins.cs_n = 1'b1; // R7
                    d.pins.we_n = 1'b1; // R7
                    tmr_load    = 1'b1;
                    tmr_val     = phase_len(RC_CYC - WLO_CYC); // R21
                end
            end
            ST_WEND: begin
                if (tmr_done) begin
                    d.st           = ST_IDLE;
                    d.pins.dq_oe_n = 1'b1; // R20
                    d.ready        = 1'b1;
                end
            end
            ST_RD: begin
                if (tmr_done) begin
                    cap_en      = 1'b1; // R9
                    d.st        = ST_TURN;
                    d.pins.cs_n = 1'b1;
                    d.pins.oe_n = 1'b1;
                    tmr_load    = 1'b1;
                    tmr_val     = phase_len(HZ_CYC); // R11 R12
                end
            end
            ST_TURN: begin
                // Memory may still drive; no write data until it floats.
                if (tmr_done) begin
                    d.st    = ST_IDLE; // R15
                    d.ready = 1'b1;
                end
            end
            ST_RET: begin
                d.pins.cs_n = 1'b1; // R22
                if (!retain_req) begin
                    d.st     = ST_RECOV;
                    tmr_load = 1'b1;
                    tmr_val  = phase_len(RC_CYC); // R22
                end
            end
            ST_RECOV: begin
                if (tmr_done) begin
                    d.st       = ST_IDLE;
                    d.ready    = 1'b1;
                    d.retained = 1'b0;
                end
            end
            default: begin
                d = STATE_RST;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    asr_timer u_timer (
        .clock    (clock),
        .nrst     (nrst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    asr_capture u_capture (
        .clock  (clock),
        .nrst   (nrst),
        .cap_en (cap_en),
        .din    (sram_dq_i),
        .rsp    (rsp)
    );

    assign req_ready = q.ready;
    assign retained  = q.retained;
    assign pins      = q.pins;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_write_strobes: assert property ( // R3
        !pins.we_n |-> !pins.cs_n && pins.oe_n
    ) else $error("write strobe low without select");

    a_write_select: assert property ( // R4
        $fell(pins.we_n) |-> (!pins.cs_n && !pins.we_n)[*7]
    ) else $error("select too short before write end");

    a_write_length: assert property ( // R5
        $fell(pins.we_n) |->
            (!pins.we_n)[*8] ##1 (!pins.we_n)[*3] ##1 pins.we_n
    ) else $error("write pulse not eleven cycles");

    a_addr_stable: assert property ( // R23
        !pins.cs_n && !$past(pins.cs_n) |-> $stable(pins.addr)
    ) else $error("address moved while selected");

    a_data_overlap: assert property ( // R6
        !pins.we_n && !$past(pins.we_n) |->
            !pins.dq_oe_n && $stable(pins.dout)
    ) else $error("write data not held during pulse");

    a_write_end: assert property ( // R7
        $rose(pins.we_n) |-> $rose(pins.cs_n) && !pins.dq_oe_n
            ##1 pins.dq_oe_n
    ) else $error("write end sequence wrong");

    a_no_contention: assert property ( // R15
        !pins.dq_oe_n |-> pins.oe_n
    ) else $error("host drives while output enabled");

    a_select_with_we: assert property ( // R16
        $fell(pins.we_n) |-> $fell(pins.cs_n)
    ) else $error("select did not fall with write");

    a_read_cycle: assert property ( // R21
        $fell(pins.oe_n) |->
            (!pins.oe_n && pins.we_n)[*8] ##1
            (!pins.oe_n && pins.we_n)[*4] ##1 pins.oe_n
    ) else $error("read cycle not twelve cycles");

    a_read_resp: assert property ( // R9
        $rose(pins.oe_n) |-> rsp.valid && !$past(pins.cs_n)
    ) else $error("read data not captured at cycle end");

    a_turnaround: assert property ( // R11
        $rose(pins.oe_n) |-> (pins.dq_oe_n && !req_ready)[*4]
    ) else $error("turnaround shorter than float time");

    a_retain_cs: assert property ( // R22
        retained |-> pins.cs_n && !req_ready
    ) else $error("selected during retention");

    // Pin strobe, request port and retention checks, with timing counted in clock cycles.
    // The counts follow RC_CYC = 12, WLO_CYC = 11 and HZ_CYC = 4.

    a_read_strobes: assert property ( // R8
        !pins.oe_n |-> pins.we_n && !pins.cs_n && pins.dq_oe_n
    ) else $error("read strobes inconsistent");

    a_idle_pins: assert property ( // R15
        req_ready |-> pins.cs_n && pins.we_n && pins.oe_n && pins.dq_oe_n
    ) else $error("memory pins active while idle");

    a_addr_taken: assert property ( // R23
        $fell(pins.cs_n) |-> pins.addr == $past(req.addr)
    ) else $error("address not taken from request");

    a_read_select: assert property ( // R23
        $fell(pins.oe_n) |-> $fell(pins.cs_n) && pins.we_n
    ) else $error("read enable did not fall with select");

    a_wdata_taken: assert property ( // R6
        $fell(pins.we_n) |-> pins.dout == $past(req.wdata) && !pins.dq_oe_n
    ) else $error("write data not taken from request");

    a_take_busy: assert property ( // R21
        req_valid && req_ready |=> !req_ready
    ) else $error("ready stayed high after a take");

    a_write_busy: assert property ( // R21
        $fell(pins.we_n) |->
            (!req_ready)[*8] ##1 (!req_ready)[*4] ##1 req_ready
    ) else $error("write cycle not twelve cycles");

    a_read_release: assert property ( // R21
        $rose(pins.oe_n) |-> ##4 req_ready
    ) else $error("ready not back after read turnaround");

    a_valid_pulse: assert property ( // R21
        rsp.valid |-> $rose(pins.cs_n) && !req_ready ##1 !rsp.valid
    ) else $error("read response not a single pulse at cycle end");

    a_strobe_release: assert property ( // R7
        $rose(pins.cs_n) |-> pins.we_n && pins.oe_n
    ) else $error("strobe still low after deselect");

    a_write_turn: assert property ( // R20
        $rose(pins.dq_oe_n) |-> pins.cs_n && req_ready
    ) else $error("data driver released at wrong time");

    a_retain_entry: assert property ( // R22
        retain_req && req_ready && !req_valid |=> retained
    ) else $error("retention not entered");

    a_recovery_len: assert property ( // R22
        $fell(retain_req) && retained |->
            (retained && pins.cs_n)[*8] ##1 (retained && pins.cs_n)[*5]
            ##1 !retained && req_ready
    ) else $error("recovery not one read cycle");

endmodule

/* File: tb/asr_sram_model.sv */
// Behavioural 2K x 8 static RAM that answers the host controller pins.
`timescale 1ns/1ps
`include "asr_map.svh"
module asr_sram_model
    import asr_pkg::*;
(
    input  asr_pins_t                   pins,
    input  wire logic                   slow,
    input  wire logic [`ASR_DATA_W-1:0] dq,
    output logic                        drv,
    output logic [`ASR_DATA_W-1:0]      q
);
    logic [`ASR_DATA_W-1:0] mem [`ASR_WORDS];
    logic                   wr_on;
    logic                   rd_on;
    logic                   wr_seen;

    initial begin
        drv = 1'b0;
        wr_seen = 1'b0;
    end
    assign wr_on = !pins.cs_n && !pins.we_n;
    // A cycle that began as a write never drives the pins back.
    always @(posedge wr_on or posedge pins.cs_n) begin
        wr_seen <= wr_on;
    end
    assign rd_on = !pins.cs_n && !pins.oe_n && pins.we_n && !wr_seen;
    always @(negedge wr_on) begin
        mem[pins.addr] <= dq;
    end
    always @(rd_on) begin
        if (rd_on) begin
            drv <= #(slow ? 115 : 20) 1'b1;
        end else begin
            drv <= #5 1'b0;
        end
    end
    assign q = mem[pins.addr];
endmodule

/* File: tb/asr_host_bench.sv */
// Self-checking bench for the static RAM host controller.
`timescale 1ns/1ps
`include "asr_map.svh"
module asr_host_bench
    import asr_pkg::*;
;
    logic        clock;
    logic        nrst;
    logic        req_valid;
    logic        retain_req;
    logic        slow;
    logic        req_ready;
    logic        retained;
    logic        m_drv;
    asr_req_t    req;
    asr_rsp_t    rsp;
    asr_pins_t   pins;
    logic [7:0]  m_q;
    logic [7:0]  dq_w;
    logic [7:0]  dq_last;
    logic [7:0]  rd;
    int          n_mismatch;
    int          total_checks;

    asr_host dut (
        .clock      (clock),
        .nrst       (nrst),
        .req_valid  (req_valid),
        .req        (req),
        .req_ready  (req_ready),
        .rsp        (rsp),
        .retain_req (retain_req),
        .retained   (retained),
        .pins       (pins),
        .sram_dq_i  (dq_w)
    );
    asr_sram_model u_ram (
        .pins (pins),
        .slow (slow),
        .dq   (dq_w),
        .drv  (m_drv),
        .q    (m_q)
    );

    // An undriven bus shows the inverse of its level at the last clock edge, so it toggles every cycle.
    always_comb begin
        if (pins.dq_oe_n === 1'b0) dq_w = pins.dout;
        else if (m_drv === 1'b1) dq_w = m_q;
        else dq_w = ~dq_last;
    end
    always @(posedge clock) dq_last <= dq_w;

    task automatic ck_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ck_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ck_cnt(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic op(input logic w, input logic [10:0] a,
                      input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        req_valid = 1'b1;
        req = '{write: w, addr: a, wdata: d};
        @(negedge clock);
        req_valid = 1'b0;
        ck_bit(pins.we_n, !w);
        ck_bit(pins.oe_n, w);
        ck_bit(pins.dq_oe_n, !w);
        n = 0;
        q = 8'h00;
        while (req_ready !== 1'b1 && n < 40) begin
            if (rsp.valid === 1'b1) begin
                ck_cnt(n, 12);
                q = rsp.data;
            end
            ck_bit(pins.cs_n, n >= (w ? 11 : 12));
            if (pins.cs_n === 1'b0) ck_val(16'(pins.addr), 16'(a));
            if (w && pins.cs_n === 1'b0) ck_val(16'(pins.dout), 16'(d));
            @(negedge clock);
            n++;
        end
        ck_cnt(n, w ? 12 : 16);
    endtask

    task automatic t_reset;
        ck_bit(pins.cs_n, 1'b1);
        ck_bit(pins.we_n, 1'b1);
        ck_bit(pins.dq_oe_n, 1'b1);
        ck_bit(req_ready, 1'b1);
        ck_val(16'(rsp), 16'h0000);
        ck_bit(retained, 1'b0);
    endtask

    task automatic t_rw;
        logic [10:0] a [4] = '{11'h000, 11'h7FF, 11'h001, 11'h400};
        logic [7:0]  d [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
        for (int i = 0; i < 4; i++) op(1'b1, a[i], d[i], rd);
        op(1'b1, 11'h000, 8'h3C, rd);
        for (int i = 1; i < 4; i++) begin
            op(1'b0, a[i], 8'h00, rd);
            ck_val(16'(rd), 16'(d[i]));
        end
        op(1'b0, 11'h000, 8'h00, rd);
        ck_val(16'(rd), 16'h003C);
    endtask

    task automatic t_slow;
        slow = 1'b1;
        op(1'b0, 11'h7FF, 8'h00, rd);
        ck_val(16'(rd), 16'h005A);
        slow = 1'b0;
    endtask

    task automatic t_retain;
        int n;
        retain_req = 1'b1;
        @(negedge clock);
        ck_bit(retained, 1'b1);
        ck_bit(req_ready, 1'b0);
        req_valid = 1'b1;
        req = '{write: 1'b1, addr: 11'h001, wdata: 8'h77};
        repeat (5) @(negedge clock);
        ck_bit(pins.cs_n, 1'b1);
        ck_bit(req_ready, 1'b0);
        retain_req = 1'b0;
        n = 0;
        while (retained !== 1'b0 && n < 40) begin
            @(negedge clock);
            n++;
        end
        ck_cnt(n, 13);
        ck_bit(req_ready, 1'b1);
        @(negedge clock);
        req_valid = 1'b0;
        op(1'b0, 11'h001, 8'h00, rd);
        ck_val(16'(rd), 16'h0077);
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        nrst = 1'b0;
        req_valid = 1'b0;
        retain_req = 1'b0;
        slow = 1'b0;
        req = '0;
        dq_last = 8'h00;
        n_mismatch = 0;
        total_checks = 0;
        repeat (10) @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
        t_reset;
        t_rw;
        t_slow;
        t_retain;
        wrap_up;
    end
    initial begin
        #20000;
        n_mismatch++;
        wrap_up;
    end
endmodule
